// *** common/dpr_defs.svh ***
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH

// Array and lock space geometry
`define DPR_ADDR_W      12
`define DPR_DATA_W      9
`define DPR_LOCK_W      3
`define DPR_LOCK_COUNT  8
`define DPR_LOCK_LAST   3'h7

// Mailbox words
`define DPR_MBOX_LEFT   12'hFFE
`define DPR_MBOX_RIGHT  12'hFFF

// Clock period and pin timing in ns
`define DPR_CLK_NS      8
`define DPR_T_PWE_NS    12
`define DPR_T_SD_NS     10
`define DPR_T_HA_NS     2
`define DPR_T_BLA_NS    15
`define DPR_T_ACC_NS    15
`define DPR_T_DDD_NS    25
`define DPR_T_SOP_NS    10

// Least times, rounded up to whole cycles
`define DPR_CYC(t)      (((t) + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_PWE_CYC     `DPR_CYC(`DPR_T_PWE_NS)
`define DPR_SD_CYC      `DPR_CYC(`DPR_T_SD_NS)
`define DPR_HA_CYC      `DPR_CYC(`DPR_T_HA_NS)
`define DPR_BLA_CYC     `DPR_CYC(`DPR_T_BLA_NS)
`define DPR_ACC_CYC     `DPR_CYC(`DPR_T_ACC_NS)
`define DPR_DDD_CYC     `DPR_CYC(`DPR_T_DDD_NS)
`define DPR_SOP_CYC     `DPR_CYC(`DPR_T_SOP_NS)

// Latency of the pin input synchroniser
`define DPR_SYNC_LAT    3

`endif

// *** common/dpr_pkg.sv ***
`default_nettype none

package dpr_pkg;

    typedef enum logic [2:0] {
        DPR_OP_READ,
        DPR_OP_WRITE,
        DPR_OP_LOCK_TAKE,
        DPR_OP_LOCK_GIVE,
        DPR_OP_LOCK_INIT
    } dpr_op_type;

    typedef enum logic [2:0] {
        DPR_ST_IDLE,
        DPR_ST_SETUP,
        DPR_ST_WRITE,
        DPR_ST_HOLD,
        DPR_ST_GAP,
        DPR_ST_READ,
        DPR_ST_DONE
    } dpr_state_type;

endpackage

`default_nettype wire

// *** common/dpr_in_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface dpr_in_if #(
    parameter int DW = 9
);
    logic [DW-1:0] raw_data;
    logic          raw_busy_n;
    logic          raw_flag_n;
    logic [DW-1:0] clean_data;
    logic          clean_busy_n;
    logic          clean_flag_n;

    modport sync (
        input  raw_data,
        input  raw_busy_n,
        input  raw_flag_n,
        output clean_data,
        output clean_busy_n,
        output clean_flag_n
    );

    modport ctl (
        output raw_data,
        output raw_busy_n,
        output raw_flag_n,
        input  clean_data,
        input  clean_busy_n,
        input  clean_flag_n
    );
endinterface

`default_nettype wire

// *** hdl/dpr_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module dpr_pin_sync #(
    parameter int DW = 9
) (
    input  wire logic clk,
    input  wire logic resetn,
    dpr_in_if.sync    pins
);
    localparam int W = DW + 2;

    logic [W-1:0] raw;
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;
    logic [W-1:0] out_nxt;

    assign raw = {pins.raw_flag_n, pins.raw_busy_n, pins.raw_data};

    // Idle pin levels are high; data lines float high-ish, so reset to ones
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '1;
            s2_r <= '1;
            s3_r <= '1;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once the second and third stages agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
        end
    endgenerate

    // One process owns the whole vector, so each bit has a single driver
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_r <= '1;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign pins.clean_data   = out_r[DW-1:0];
    assign pins.clean_busy_n = out_r[DW];
    assign pins.clean_flag_n = out_r[DW+1];
endmodule

`default_nettype wire

// *** hdl/dpr_host.sv ***
// What this block does
// - Write lasts while write strobe and one select are low; both rise on the same edge.
// - Write strobe stays high whenever the address lines change.
// - Writes start only after the wait input has settled.
// - Chip select is never low together with lock select.
// - After a lock take write, selects release for the update pulse before readback.
// - The lock init op writes one to every lock so this port holds none.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_defs.svh"

module dpr_host
    import dpr_pkg::*;
#(
    parameter int AW = `DPR_ADDR_W,
    parameter int DW = `DPR_DATA_W
) (
    input  wire logic          clk,
    input  wire logic          resetn,
    // User command port
    input  wire logic          req_valid,
    output logic               req_ready,
    input  wire dpr_op_type    req_op,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    output logic               rsp_valid,
    output logic [DW-1:0]      rsp_rdata,
    output logic               rsp_won,
    output logic               doorbell,
    // Device port pins
    output logic               chip_sel_n,
    output logic               lock_space_select_low,
    output logic               out_en_n,
    output logic               write_n,
    output logic [AW-1:0]      addr,
    output logic [DW-1:0]      data_o,
    output logic               data_oe,
    input  wire logic [DW-1:0] data_i,
    input  wire logic          busy_n,
    input  wire logic          flag_n
);
    localparam logic [7:0] SETTLE_CYC =
        8'(`DPR_BLA_CYC + `DPR_SYNC_LAT);
    localparam logic [7:0] WR_CYC =
        8'((`DPR_PWE_CYC > `DPR_SD_CYC) ? `DPR_PWE_CYC : `DPR_SD_CYC);
    localparam logic [7:0] HA_CYC  = 8'(`DPR_HA_CYC);
    localparam logic [7:0] SOP_CYC = 8'(`DPR_SOP_CYC);
    localparam logic [7:0] RD_CYC  =
        8'(((`DPR_DDD_CYC > `DPR_ACC_CYC) ? `DPR_DDD_CYC : `DPR_ACC_CYC)
           + `DPR_SYNC_LAT);

    dpr_in_if #(.DW(DW)) pin_in ();

    assign pin_in.raw_data   = data_i;
    assign pin_in.raw_busy_n = busy_n;
    assign pin_in.raw_flag_n = flag_n;

    dpr_pin_sync #(.DW(DW)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .pins   (pin_in.sync)
    );

    dpr_state_type       state_r;
    dpr_state_type       state_nxt;
    dpr_op_type          op_r;
    logic [7:0]          cnt_r;
    logic [7:0]          cnt_nxt;
    logic                rd_phase_r;
    logic [AW-1:0]       addr_r;
    logic [DW-1:0]       wdata_r;
    logic [`DPR_LOCK_W-1:0] lock_idx_r;

    function automatic logic is_lock(input dpr_op_type op);
        return op == DPR_OP_LOCK_TAKE || op == DPR_OP_LOCK_GIVE ||
               op == DPR_OP_LOCK_INIT;
    endfunction

    function automatic logic writes_now(input dpr_op_type op,
                                        input logic rd_phase);
        return op == DPR_OP_WRITE || op == DPR_OP_LOCK_GIVE ||
               op == DPR_OP_LOCK_INIT ||
               (op == DPR_OP_LOCK_TAKE && !rd_phase);
    endfunction

    assign req_ready = (state_r == DPR_ST_IDLE);

    // Sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
        case (state_r)
            DPR_ST_IDLE: begin
                if (req_valid) begin
                    state_nxt = DPR_ST_SETUP;
                    cnt_nxt   = SETTLE_CYC;
                end
            end
            DPR_ST_SETUP: begin
                // Wait is watched only after it has had time to settle
                if (cnt_r == 8'h00 &&
                    (is_lock(op_r) || pin_in.clean_busy_n)) begin
                    if (writes_now(op_r, rd_phase_r)) begin
                        state_nxt = DPR_ST_WRITE;
                        cnt_nxt   = WR_CYC;
                    end else begin
                        state_nxt = DPR_ST_READ;
                        cnt_nxt   = RD_CYC;
                    end
                end
            end
            DPR_ST_WRITE: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = DPR_ST_HOLD;
                    cnt_nxt   = HA_CYC;
                end
            end
            DPR_ST_HOLD: begin
                if (cnt_r == 8'h00) begin
                    if (op_r == DPR_OP_LOCK_TAKE) begin
                        state_nxt = DPR_ST_GAP;
                        cnt_nxt   = SOP_CYC;
                    end else if (op_r == DPR_OP_LOCK_INIT &&
                                 lock_idx_r != `DPR_LOCK_LAST) begin
                        state_nxt = DPR_ST_SETUP;
                        cnt_nxt   = SETTLE_CYC;
                    end else begin
                        state_nxt = DPR_ST_DONE;
                    end
                end
            end
            DPR_ST_GAP: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = DPR_ST_SETUP;
                    cnt_nxt   = SETTLE_CYC;
                end
            end
            DPR_ST_READ: begin
                if (cnt_r == 8'h00) begin
                    state_nxt = DPR_ST_DONE;
                end
            end
            DPR_ST_DONE: begin
                state_nxt = DPR_ST_IDLE;
            end
            default: begin
                state_nxt = DPR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= DPR_ST_IDLE;
            cnt_r   <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Command capture; address only moves while the strobe is high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            op_r       <= DPR_OP_READ;
            addr_r     <= '0;
            wdata_r    <= '0;
            lock_idx_r <= '0;
            rd_phase_r <= 1'b0;
        end else if (state_r == DPR_ST_IDLE && req_valid) begin
            op_r       <= req_op;
            addr_r     <= req_addr;
            lock_idx_r <= (req_op == DPR_OP_LOCK_INIT) ?
                          '0 : req_addr[`DPR_LOCK_W-1:0];
            rd_phase_r <= 1'b0;
            case (req_op)
                DPR_OP_LOCK_TAKE: wdata_r <= '0;
                DPR_OP_LOCK_GIVE,
                DPR_OP_LOCK_INIT: wdata_r <= DW'(1);
                default:          wdata_r <= req_wdata;
            endcase
        end else if (state_r == DPR_ST_GAP) begin
            rd_phase_r <= 1'b1;
        end else if (state_r == DPR_ST_HOLD && state_nxt == DPR_ST_SETUP) begin
            lock_idx_r <= lock_idx_r + 1'b1;
        end
    end

    // Pin drive, registered from the next state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chip_sel_n            <= 1'b1;
            lock_space_select_low <= 1'b1;
            out_en_n              <= 1'b1;
            write_n               <= 1'b1;
            addr                  <= '0;
            data_o                <= '0;
            data_oe               <= 1'b0;
        end else begin
            case (state_nxt)
                DPR_ST_SETUP, DPR_ST_WRITE, DPR_ST_READ: begin
                    // Never both selects low at once
                    chip_sel_n            <= is_lock(op_r);
                    lock_space_select_low <= !is_lock(op_r);
                end
                default: begin
                    chip_sel_n            <= 1'b1;
                    lock_space_select_low <= 1'b1;
                end
            endcase
            write_n  <= (state_nxt != DPR_ST_WRITE);
            out_en_n <= (state_nxt != DPR_ST_READ);
            data_oe  <= (state_nxt == DPR_ST_WRITE);
            data_o   <= wdata_r;
            if (state_nxt == DPR_ST_SETUP) begin
                // Strobe is high in every state that enters setup
                addr <= is_lock(op_r) ?
                        AW'(lock_idx_r) : addr_r;
            end
        end
    end

    // Response; a lock is held when bit 0 reads back low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_won   <= 1'b0;
        end else begin
            rsp_valid <= (state_r == DPR_ST_DONE);
            if (state_r == DPR_ST_READ && cnt_r == 8'h00) begin
                rsp_rdata <= pin_in.clean_data;
                rsp_won   <= (op_r == DPR_OP_LOCK_TAKE) &&
                             !pin_in.clean_data[0];
            end
        end
    end

    // Doorbell toward this port; reading the own mailbox clears it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            doorbell <= 1'b0;
        end else begin
            doorbell <= !pin_in.clean_flag_n;
        end
    end
endmodule

`default_nettype wire

// *** dv/dpr_host_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module dpr_host_monitor (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        doorbell,
    input wire logic        chip_sel_n,
    input wire logic        lock_space_select_low,
    input wire logic        out_en_n,
    input wire logic        write_n,
    input wire logic [11:0] addr,
    input wire logic        data_oe,
    input wire logic        busy_n,
    input wire logic        flag_n
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_sel_apart: assert property (
        chip_sel_n || lock_space_select_low)
        else $error("both selects low");
    a_addr_quiet: assert property (
        !$stable(addr) |-> write_n && $past(write_n))
        else $error("address moved in write");
    a_write_sel: assert property (
        !write_n |-> !chip_sel_n || !lock_space_select_low)
        else $error("strobe without select");
    a_drive_write: assert property (
        data_oe |-> !write_n && out_en_n)
        else $error("data driven outside write");
    a_read_sel: assert property (
        !out_en_n |-> write_n && !(chip_sel_n && lock_space_select_low))
        else $error("read without select");
    a_strobe_width: assert property (
        $fell(write_n) |-> (!write_n)[*3] ##1 write_n)
        else $error("write pulse width");
    a_busy_hold: assert property (
        (!busy_n)[*8] |-> write_n && out_en_n)
        else $error("access during wait");
    a_bell_follow: assert property (
        (!flag_n)[*6] |-> doorbell)
        else $error("doorbell missed");
endmodule

bind dpr_host dpr_host_monitor u_mon (
    .clk, .resetn, .doorbell, .chip_sel_n, .lock_space_select_low,
    .out_en_n, .write_n, .addr, .data_oe, .busy_n, .flag_n
);

`default_nettype wire

// *** dv/dpr_dev_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module dpr_dev_model (
    input  wire logic        chip_sel_n,
    input  wire logic        lock_space_select_low,
    input  wire logic        out_en_n,
    input  wire logic        write_n,
    input  wire logic [11:0] addr,
    input  wire logic [8:0]  data_o,
    input  wire logic        data_oe,
    output logic [8:0]       data_i,
    output logic             busy_n,
    output logic             flag_n,
    output logic             r_flag_n
);
    logic [8:0]  mem [4096];
    logic [8:0]  wd, last_v, rv = 9'h0AA;
    logic [11:0] wa, ra, r_addr = 12'h000;
    logic        wlk, rce, r_sel = 1'b0;
    int          own [8];
    bit          rq [2][8];
    wire ce = !chip_sel_n && lock_space_select_low;
    wire lk = chip_sel_n && !lock_space_select_low;
    wire wr = !write_n && (ce || lk);
    wire rd = !out_en_n && write_n && (ce || lk);

    // Locks start held by the far side: only a far-side write of one frees them
    initial begin
        flag_n = 1'b1;
        r_flag_n = 1'b1;
        foreach (own[i]) begin
            own[i] = 2;
            rq[1][i] = 1'b1;
        end
    end

    task automatic lock_wr(int s, int i, bit b);
        rq[s][i] = !b;
        if (!b && own[i] == 0) own[i] = s + 1;
        if (b && own[i] == s + 1) own[i] = rq[1-s][i] ? 2 - s : 0;
    endtask

    task automatic r_write(logic [11:0] a, logic [8:0] d);
        mem[a] = d;
        if (a == 12'hFFE) flag_n = 1'b0;
    endtask

    task automatic r_read(logic [11:0] a, output logic [8:0] d);
        d = mem[a];
        if (a == 12'hFFF) r_flag_n = 1'b1;
    endtask

    always @* begin
        if (wr && data_oe) begin
            wa = addr;
            wd = data_o;
            wlk = lk;
        end
    end

    always @(negedge wr) begin
        if (wlk) lock_wr(0, wa[2:0], wd[0]);
        else mem[wa] = wd;
        if (!wlk && wa == 12'hFFF) r_flag_n = 1'b0;
    end

    // Frozen at read start so a far-side lock write cannot tear it
    always @(posedge rd) begin
        ra = addr;
        rce = ce;
        rv = lk ? {9{own[addr[2:0]] != 1}} : mem[addr];
    end

    always @(negedge rd) begin
        last_v = rv;
        if (rce && ra == 12'hFFE) flag_n = 1'b1;
    end

    // Released lines show the inverse of the last value, not a stale copy
    assign data_i = data_oe ? data_o : rd ? rv : ~last_v;
    // Master role: far side holds the word and wins every match
    assign busy_n = !(r_sel && !chip_sel_n && addr == r_addr);
endmodule

`default_nettype wire

// *** dv/dpr_host_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module dpr_host_tb
    import dpr_pkg::*;
;
    logic        clk = 1'b0, resetn = 1'b0, req_valid = 1'b0;
    dpr_op_type  req_op = DPR_OP_READ;
    logic [11:0] req_addr = 12'h000, addr;
    logic [8:0]  req_wdata = 9'h000, rsp_rdata, data_o, data_i, rd9;
    logic        req_ready, rsp_valid, rsp_won, doorbell, chip_sel_n;
    logic        lock_space_select_low, out_en_n, write_n, data_oe;
    logic        busy_n, flag_n, r_flag_n;
    int          fail_count = 0, tests_run = 0, cyc = 0, seed, i;
    int          lo [8];
    bit          lr [2][8];
    logic [8:0]  em [int];
    logic [11:0] aq [$];

    dpr_host dut (
        .clk, .resetn, .req_valid, .req_ready, .req_op, .req_addr,
        .req_wdata, .rsp_valid, .rsp_rdata, .rsp_won, .doorbell,
        .chip_sel_n, .lock_space_select_low, .out_en_n, .write_n,
        .addr, .data_o, .data_oe, .data_i, .busy_n, .flag_n
    );
    dpr_dev_model m (
        .chip_sel_n, .lock_space_select_low, .out_en_n, .write_n, .addr,
        .data_o, .data_oe, .data_i, .busy_n, .flag_n, .r_flag_n
    );

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish;
        if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Run needs about 1400 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish;
        end
    end

    task automatic check(logic [11:0] seen, logic [11:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(dpr_op_type op, logic [11:0] a, logic [8:0] d);
        int n;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 3000 && rsp_valid !== 1'b1; n++) @(negedge clk);
        check(rsp_valid, 1'b1);
    endtask

    function automatic void tl(int s, int k, bit b);
        lr[s][k] = !b;
        if (!b && lo[k] == 0) lo[k] = s + 1;
        if (b && lo[k] == s + 1) lo[k] = lr[1-s][k] ? 2 - s : 0;
    endfunction

    // Upper address bits are random: only the low three pick a lock
    task automatic lock_op(dpr_op_type op, int k);
        logic [11:0] a;
        a = 12'($random(seed));
        a[2:0] = 3'(k);
        cmd(op, a, 9'h000);
        tl(0, k, op != DPR_OP_LOCK_TAKE);
        if (op == DPR_OP_LOCK_TAKE) begin
            check(rsp_won, lo[k] == 1);
            check(rsp_rdata[7:0], lo[k] == 1 ? 8'h00 : 8'hFF);
        end
        check(m.own[k], lo[k]);
    endtask

    initial begin
        seed = 32'hECD55041;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        check({chip_sel_n, out_en_n, write_n, data_oe}, 4'hE);
        check({req_ready, rsp_valid, doorbell}, 3'h4);
        check({lock_space_select_low, addr}, 13'h1000);
        cmd(DPR_OP_LOCK_INIT, 12'h000, 9'h000);
        for (i = 0; i < 8; i++) begin
            m.lock_wr(1, i, 1'b1);
            tl(0, i, 1'b1);
            tl(1, i, 1'b1);
            check(m.own[i], 0);
        end
        aq = '{12'h000, 12'hFFD};
        for (i = 0; i < 6; i++) aq.push_back(12'($random(seed)) % 12'hFFE);
        aq.push_back(aq[2]);
        foreach (aq[k]) begin
            em[aq[k]] = 9'($random(seed));
            cmd(DPR_OP_WRITE, aq[k], em[aq[k]]);
        end
        foreach (aq[k]) begin
            cmd(DPR_OP_READ, aq[k], 9'h000);
            check(rsp_rdata, em[aq[k]]);
        end
        cmd(DPR_OP_WRITE, 12'hFFF, 9'h15A);
        check(r_flag_n, 1'b0);
        m.r_read(12'hFFF, rd9);
        check(rd9, 9'h15A);
        check(r_flag_n, 1'b1);
        m.r_write(12'hFFE, 9'h0A5);
        repeat (8) @(negedge clk);
        check(doorbell, 1'b1);
        cmd(DPR_OP_READ, 12'hFFE, 9'h000);
        check(rsp_rdata, 9'h0A5);
        repeat (8) @(negedge clk);
        check(doorbell, 1'b0);
        m.r_addr = aq[1];
        m.r_sel = 1'b1;
        em[aq[1]] = 9'($random(seed));
        fork
            cmd(DPR_OP_WRITE, aq[1], em[aq[1]]);
            begin
                repeat (40) @(negedge clk);
                check(write_n, 1'b1);
                m.r_sel = 1'b0;
            end
        join
        cmd(DPR_OP_READ, aq[1], 9'h000);
        check(rsp_rdata, em[aq[1]]);
        for (i = 0; i < 8; i++) begin
            lock_op(DPR_OP_LOCK_TAKE, i);
            m.lock_wr(1, i, 1'b0);
            tl(1, i, 1'b0);
            lock_op(DPR_OP_LOCK_GIVE, i);
            lock_op(DPR_OP_LOCK_TAKE, i);
            m.lock_wr(1, i, 1'b1);
            tl(1, i, 1'b1);
            lock_op(DPR_OP_LOCK_TAKE, i);
            lock_op(DPR_OP_LOCK_GIVE, i);
        end
        tally_and_finish;
    end
endmodule

`default_nettype wire
